// [hdl/pfdc_top.sv]
// What this block does
// R01: Holds 27-bit numerator over two-to-27 denominator
// R02: Numerator commits when top byte written
// R03: 10-bit integer divider resets to 6C
// R04: Integer commits when upper byte written
// R05: Two-bit modulator order, resets third order
// R06: Dither enable bit, off after reset
// R07: Dither shaping select bit, resets unshaped
// R08: Dither gain one to eight steps
// R09: Reference select: crystal zero, pin one
// R10: Doubler enable bit, resets enabled
// R11: Oscillator filter bypass bit, resets not bypassed
// R12: Three-bit pole capacitor code, resets 7
// R13: Four-bit filter resistor code, resets 6
// R14: Integer order ignores fractional numerator
`timescale 1ns/1ps
`default_nettype none
module pfdc_top
	import pfdc_pkg::*;
(
	// Clock and reset
	input wire logic CLK_SYS_I,
	input wire logic RST_N_I,
	// Register port
	input wire logic [7:0] ADDR_I,
	input wire logic [31:0] WDATA_I,
	input wire logic [3:0] BE_I,
	input wire logic WR_I,
	input wire logic RD_I,
	output logic [31:0] RDATA_O,
	// Feedback divider to PLL core
	output logic [9:0] FEEDBACK_INTEGER_VALUE_O,
	output logic [26:0] FEEDBACK_FRACTION_NUMERATOR_O,
	output logic [1:0] MODULATOR_ORDER_O,
	output logic DITHER_ENABLE_O,
	output logic DITHER_SHAPING_ENABLE_O,
	output logic [3:0] DITHER_STEP_O,
	// Reference path
	output logic REF_SEL_CLOCK_INPUT_PIN_O,
	output logic DOUBLER_ENABLE_O,
	// Loop filter
	output logic VCO_FILTER_BYPASS_O,
	output logic [2:0] POLE_CAPACITOR_CODE_O,
	output logic [3:0] FILTER_RESISTOR_CODE_O,
	output logic [7:0] POLE_CAPACITOR_SEL_O,
	output logic [15:0] FILTER_RESISTOR_SEL_O
);
	// ==========================================================
	// Address decode
	logic hit_frac;
	logic hit_int;
	logic hit_sdm;
	logic hit_ref;
	logic hit_lpf;
	logic hit_sts;
	assign hit_frac = (ADDR_I == PFDC_OFS_FRAC);
	assign hit_int = (ADDR_I == PFDC_OFS_INT);
	assign hit_sdm = (ADDR_I == PFDC_OFS_SDM);
	assign hit_ref = (ADDR_I == PFDC_OFS_REF);
	assign hit_lpf = (ADDR_I == PFDC_OFS_LPF);
	assign hit_sts = (ADDR_I == PFDC_OFS_STS);

	// ==========================================================
	// Byte-lane staging of the atomic registers
	// Lower lanes land in a staging word; the top lane commits all.
	logic [31:0] frac_stage;
	logic [15:0] int_stage;
	logic [31:0] frac_merged;
	logic [15:0] int_merged;
	logic frac_commit;
	logic int_commit;
	logic frac_low_wr;
	logic int_low_wr;
	genvar b;
	generate
		for (b = 0; b < 4; b++) begin : g_frac_lane
			assign frac_merged[b*8 +: 8] = BE_I[b] ? WDATA_I[b*8 +: 8] : frac_stage[b*8 +: 8];
		end
		for (b = 0; b < 2; b++) begin : g_int_lane
			assign int_merged[b*8 +: 8] = BE_I[b] ? WDATA_I[b*8 +: 8] : int_stage[b*8 +: 8];
		end
	endgenerate
	assign frac_commit = WR_I && hit_frac && BE_I[PFDC_FRAC_TOP_LANE]; // R02
	assign int_commit = WR_I && hit_int && BE_I[PFDC_INT_TOP_LANE]; // R04
	assign frac_low_wr = WR_I && hit_frac && !BE_I[PFDC_FRAC_TOP_LANE];
	assign int_low_wr = WR_I && hit_int && !BE_I[PFDC_INT_TOP_LANE];

	always_ff @(posedge CLK_SYS_I) begin
		if (!RST_N_I) begin
			frac_stage <= {5'h00, PFDC_FRAC_RST};
			int_stage <= {6'h00, PFDC_INT_RST};
		end else begin
			if (frac_low_wr || frac_commit)
				frac_stage <= {5'h00, frac_merged[26:0]}; // R02
			if (int_low_wr || int_commit)
				int_stage <= {6'h00, int_merged[9:0]}; // R04
		end
	end

	// ==========================================================
	// Committed values that drive the PLL
	logic [26:0] frac_active;
	logic [9:0] int_active;
	pfdc_atomic_reg #(
		.W(PFDC_FRAC_W),
		.LANES(4),
		.RST(PFDC_FRAC_RST)
	) u_frac (
		.clk_i(CLK_SYS_I),
		.rst_n_i(RST_N_I),
		.wr_i(frac_commit),
		.wdata_i(frac_merged),
		.shadow_o(),
		.active_o(frac_active), // R01
		.commit_o()
	);
	pfdc_atomic_reg #(
		.W(PFDC_INT_W),
		.LANES(2),
		.RST(PFDC_INT_RST)
	) u_int (
		.clk_i(CLK_SYS_I),
		.rst_n_i(RST_N_I),
		.wr_i(int_commit),
		.wdata_i(int_merged),
		.shadow_o(),
		.active_o(int_active), // R03
		.commit_o()
	);

	// ==========================================================
	// Plain configuration registers
	logic [5:0] sdm_cfg;
	logic [1:0] ref_cfg;
	logic [7:0] lpf_cfg;
	logic sdm_wr;
	logic ref_wr;
	logic lpf_wr;
	assign sdm_wr = WR_I && hit_sdm && BE_I[0];
	assign ref_wr = WR_I && hit_ref && BE_I[0];
	assign lpf_wr = WR_I && hit_lpf && BE_I[0];
	always_ff @(posedge CLK_SYS_I) begin
		if (!RST_N_I) begin
			sdm_cfg <= PFDC_SDM_RST[5:0]; // R05 R06 R07 R08
			ref_cfg <= PFDC_REF_RST[1:0]; // R09 R10
			lpf_cfg <= PFDC_LPF_RST; // R11 R12 R13
		end else begin
			if (sdm_wr)
				sdm_cfg <= WDATA_I[5:0];
			if (ref_wr)
				ref_cfg <= WDATA_I[1:0];
			if (lpf_wr)
				lpf_cfg <= WDATA_I[7:0];
		end
	end

	// ==========================================================
	// Field extraction
	pfdc_order_t order;
	logic [1:0] gain_code;
	assign order = pfdc_order_t'(sdm_cfg[PFDC_SDM_ORDER_LSB +: 2]); // R05
	assign gain_code = sdm_cfg[PFDC_SDM_GAIN_LSB +: 2];

	// ==========================================================
	// Outputs from the configuration: divider and dither step registered, the other fields driven directly
	logic [26:0] frac_out;
	logic [3:0] dither_step;
	assign frac_out = (order == PFDC_ORD_INT) ? '0 : frac_active; // R14
	assign dither_step = 4'h1 << gain_code; // R08

	always_ff @(posedge CLK_SYS_I) begin
		if (!RST_N_I) begin
			FEEDBACK_INTEGER_VALUE_O <= PFDC_INT_RST;
			FEEDBACK_FRACTION_NUMERATOR_O <= PFDC_FRAC_RST;
			DITHER_STEP_O <= 4'h1;
		end else begin
			FEEDBACK_INTEGER_VALUE_O <= int_active; // R04
			FEEDBACK_FRACTION_NUMERATOR_O <= frac_out; // R14
			DITHER_STEP_O <= dither_step; // R08
		end
	end

	assign MODULATOR_ORDER_O = order;
	assign DITHER_ENABLE_O = sdm_cfg[PFDC_SDM_DITHER_BIT]; // R06
	assign DITHER_SHAPING_ENABLE_O = sdm_cfg[PFDC_SDM_SHAPE_BIT]; // R07
	assign REF_SEL_CLOCK_INPUT_PIN_O = ref_cfg[PFDC_REF_SEL_BIT]; // R09
	assign DOUBLER_ENABLE_O = ref_cfg[PFDC_REF_DOUBLER_BIT]; // R10
	assign VCO_FILTER_BYPASS_O = lpf_cfg[PFDC_LPF_BYP_BIT]; // R11
	assign POLE_CAPACITOR_CODE_O = lpf_cfg[PFDC_LPF_CAP_LSB +: 3]; // R12
	assign FILTER_RESISTOR_CODE_O = lpf_cfg[PFDC_LPF_RES_LSB +: 4]; // R13

	pfdc_lpf_decode u_lpf (
		.cap_code_i(lpf_cfg[PFDC_LPF_CAP_LSB +: 3]),
		.res_code_i(lpf_cfg[PFDC_LPF_RES_LSB +: 4]),
		.cap_sel_o(POLE_CAPACITOR_SEL_O), // R12
		.res_sel_o(FILTER_RESISTOR_SEL_O) // R13
	);

	// ==========================================================
	// Read path: data one cycle after the strobe
	logic [31:0] next_rdata;
	assign next_rdata = hit_frac ? {5'h00, frac_active} :
		hit_int ? {22'h000000, int_active} :
		hit_sdm ? {26'h0000000, sdm_cfg} :
		hit_ref ? {30'h00000000, ref_cfg} :
		hit_lpf ? {24'h000000, lpf_cfg} :
		hit_sts ? {5'h00, frac_stage[26:0]} :
		32'h00000000;
	always_ff @(posedge CLK_SYS_I) begin
		if (!RST_N_I)
			RDATA_O <= 32'h00000000;
		else if (RD_I)
			RDATA_O <= next_rdata;
		else
			RDATA_O <= 32'h00000000;
	end

	// ==========================================================
	// Checks
	property p_frac_hold;
		@(posedge CLK_SYS_I) disable iff (!RST_N_I)
		!frac_commit |=> (frac_active == $past(frac_active));
	endproperty
	a_frac_hold: assert property (p_frac_hold) else $error("numerator moved without top byte"); // R02

	property p_frac_commit;
		@(posedge CLK_SYS_I) disable iff (!RST_N_I)
		frac_commit |=> (frac_active == $past(frac_merged[26:0]));
	endproperty
	a_frac_commit: assert property (p_frac_commit) else $error("numerator commit lost"); // R01

	property p_int_hold;
		@(posedge CLK_SYS_I) disable iff (!RST_N_I)
		!int_commit |=> (int_active == $past(int_active));
	endproperty
	a_int_hold: assert property (p_int_hold) else $error("integer moved without upper byte"); // R04

	property p_int_out;
		@(posedge CLK_SYS_I) disable iff (!RST_N_I)
		int_commit |=> ##1 (FEEDBACK_INTEGER_VALUE_O == $past(int_merged[9:0], 2));
	endproperty
	a_int_out: assert property (p_int_out) else $error("integer not driven two cycles after commit"); // R03

	property p_int_mode;
		@(posedge CLK_SYS_I) disable iff (!RST_N_I)
		(order == PFDC_ORD_INT) |=> (FEEDBACK_FRACTION_NUMERATOR_O == 27'h0000000);
	endproperty
	a_int_mode: assert property (p_int_mode) else $error("fraction used in integer mode"); // R14

	property p_gain;
		@(posedge CLK_SYS_I) disable iff (!RST_N_I)
		1'b1 |=> (DITHER_STEP_O == {($past(gain_code) == 2'h3), ($past(gain_code) == 2'h2),
			($past(gain_code) == 2'h1), ($past(gain_code) == 2'h0)});
	endproperty
	a_gain: assert property (p_gain) else $error("dither step mismatch"); // R08

	property p_sdm_wr;
		@(posedge CLK_SYS_I) disable iff (!RST_N_I)
		sdm_wr |=> (DITHER_ENABLE_O == $past(WDATA_I[5])) && (DITHER_SHAPING_ENABLE_O == $past(WDATA_I[4]))
			&& (MODULATOR_ORDER_O == $past(WDATA_I[1:0]));
	endproperty
	a_sdm_wr: assert property (p_sdm_wr) else $error("modulator config write lost"); // R05

	property p_ref_wr;
		@(posedge CLK_SYS_I) disable iff (!RST_N_I)
		ref_wr |=> (REF_SEL_CLOCK_INPUT_PIN_O == $past(WDATA_I[1])) && (DOUBLER_ENABLE_O == $past(WDATA_I[0]));
	endproperty
	a_ref_wr: assert property (p_ref_wr) else $error("reference config write lost"); // R09

	property p_lpf_wr;
		@(posedge CLK_SYS_I) disable iff (!RST_N_I)
		lpf_wr |=> (VCO_FILTER_BYPASS_O == $past(WDATA_I[7]))
			&& (POLE_CAPACITOR_CODE_O == $past(WDATA_I[6:4]))
			&& (FILTER_RESISTOR_CODE_O == $past(WDATA_I[3:0]));
	endproperty
	a_lpf_wr: assert property (p_lpf_wr) else $error("loop filter write lost"); // R12

	property p_frac_read;
		@(posedge CLK_SYS_I) disable iff (!RST_N_I)
		(RD_I && hit_frac) |=> (RDATA_O == {5'h00, $past(frac_active)});
	endproperty
	a_frac_read: assert property (p_frac_read) else $error("numerator read back wrong"); // R01

	property p_int_read;
		@(posedge CLK_SYS_I) disable iff (!RST_N_I)
		(RD_I && hit_int) |=> (RDATA_O[31:10] == 22'h0)
			&& (RDATA_O[9:0] == $past(int_active));
	endproperty
	a_int_read: assert property (p_int_read) else $error("integer read back wrong"); // R03

	property p_frac_out;
		@(posedge CLK_SYS_I) disable iff (!RST_N_I)
		frac_commit |=> ##1 (FEEDBACK_FRACTION_NUMERATOR_O ==
			(($past(order) == PFDC_ORD_INT) ? 27'h0 : $past(frac_merged[26:0], 2)));
	endproperty
	a_frac_out: assert property (p_frac_out) else $error("numerator not driven after commit"); // R02

	property p_sdm_read;
		@(posedge CLK_SYS_I) disable iff (!RST_N_I)
		(RD_I && hit_sdm) |=> (RDATA_O[31:6] == 26'h0) && (RDATA_O[5] == $past(DITHER_ENABLE_O))
			&& (RDATA_O[1:0] == $past(MODULATOR_ORDER_O));
	endproperty
	a_sdm_read: assert property (p_sdm_read) else $error("modulator config read back wrong"); // R06

	property p_cap_sel;
		@(posedge CLK_SYS_I) disable iff (!RST_N_I)
		POLE_CAPACITOR_SEL_O == (8'h01 << POLE_CAPACITOR_CODE_O);
	endproperty
	a_cap_sel: assert property (p_cap_sel) else $error("pole capacitor steering not one-hot"); // R12

	property p_res_sel;
		@(posedge CLK_SYS_I) disable iff (!RST_N_I)
		FILTER_RESISTOR_SEL_O == (16'h0001 << FILTER_RESISTOR_CODE_O);
	endproperty
	a_res_sel: assert property (p_res_sel) else $error("filter resistor steering not one-hot"); // R13

	property p_sdm_hold;
		@(posedge CLK_SYS_I) disable iff (!RST_N_I)
		!sdm_wr |=> $stable(MODULATOR_ORDER_O) && $stable(DITHER_ENABLE_O)
			&& $stable(DITHER_SHAPING_ENABLE_O);
	endproperty
	a_sdm_hold: assert property (p_sdm_hold) else $error("modulator config moved without write"); // R07

	property p_ref_hold;
		@(posedge CLK_SYS_I) disable iff (!RST_N_I)
		!ref_wr |=> $stable(REF_SEL_CLOCK_INPUT_PIN_O) && $stable(DOUBLER_ENABLE_O);
	endproperty
	a_ref_hold: assert property (p_ref_hold) else $error("reference config moved without write"); // R10

	property p_lpf_hold;
		@(posedge CLK_SYS_I) disable iff (!RST_N_I)
		!lpf_wr |=> $stable(VCO_FILTER_BYPASS_O) && $stable(POLE_CAPACITOR_CODE_O)
			&& $stable(FILTER_RESISTOR_CODE_O);
	endproperty
	a_lpf_hold: assert property (p_lpf_hold) else $error("loop filter moved without write"); // R11

	property p_reset_div;
		@(posedge CLK_SYS_I)
		!RST_N_I |=> (FEEDBACK_INTEGER_VALUE_O == PFDC_INT_RST)
			&& (FEEDBACK_FRACTION_NUMERATOR_O == PFDC_FRAC_RST) && (RDATA_O == 32'h00000000);
	endproperty
	a_reset_div: assert property (p_reset_div) else $error("divider outputs not at reset value"); // R03

	property p_reset_sdm;
		@(posedge CLK_SYS_I)
		!RST_N_I |=> ({DITHER_ENABLE_O, DITHER_SHAPING_ENABLE_O, MODULATOR_ORDER_O}
			== {PFDC_SDM_RST[5:4], PFDC_SDM_RST[1:0]}) && (DITHER_STEP_O == 4'h1);
	endproperty
	a_reset_sdm: assert property (p_reset_sdm) else $error("modulator outputs not at reset value"); // R05

	property p_reset_lpf;
		@(posedge CLK_SYS_I)
		!RST_N_I |=> ({VCO_FILTER_BYPASS_O, POLE_CAPACITOR_CODE_O, FILTER_RESISTOR_CODE_O} == PFDC_LPF_RST)
			&& ({REF_SEL_CLOCK_INPUT_PIN_O, DOUBLER_ENABLE_O} == PFDC_REF_RST[1:0]);
	endproperty
	a_reset_lpf: assert property (p_reset_lpf) else $error("filter outputs not at reset value"); // R13
endmodule : pfdc_top
`default_nettype wire

// [pkg/pfdc_pkg.sv]
`default_nettype none
package pfdc_pkg;
	// ==========================================================
	// Register offsets (byte addresses on the plain port)
	localparam logic [7:0] PFDC_OFS_FRAC = 8'h00;
	localparam logic [7:0] PFDC_OFS_INT = 8'h04;
	localparam logic [7:0] PFDC_OFS_SDM = 8'h08;
	localparam logic [7:0] PFDC_OFS_REF = 8'h0c;
	localparam logic [7:0] PFDC_OFS_LPF = 8'h10;
	localparam logic [7:0] PFDC_OFS_STS = 8'h14;
	// ==========================================================
	// Widths and reset values
	localparam int PFDC_FRAC_W = 27;
	localparam int PFDC_INT_W = 10;
	localparam int PFDC_FRAC_DEN_LOG2 = 27;
	localparam logic [26:0] PFDC_FRAC_RST = 27'h0000000;
	localparam logic [9:0] PFDC_INT_RST = 10'h06c;
	localparam logic [7:0] PFDC_SDM_RST = 8'h03;
	localparam logic [7:0] PFDC_REF_RST = 8'h01;
	localparam logic [7:0] PFDC_LPF_RST = 8'h76;
	// ==========================================================
	// Field positions
	localparam int PFDC_SDM_ORDER_LSB = 0;
	localparam int PFDC_SDM_GAIN_LSB = 2;
	localparam int PFDC_SDM_SHAPE_BIT = 4;
	localparam int PFDC_SDM_DITHER_BIT = 5;
	localparam int PFDC_REF_DOUBLER_BIT = 0;
	localparam int PFDC_REF_SEL_BIT = 1;
	localparam int PFDC_LPF_RES_LSB = 0;
	localparam int PFDC_LPF_CAP_LSB = 4;
	localparam int PFDC_LPF_BYP_BIT = 7;
	// Byte lanes that commit the atomic registers
	localparam int PFDC_FRAC_TOP_LANE = 3;
	localparam int PFDC_INT_TOP_LANE = 1;
	// ==========================================================
	// Modulator order codes
	typedef enum logic [1:0] {
		PFDC_ORD_INT = 2'h0,
		PFDC_ORD_1ST = 2'h1,
		PFDC_ORD_2ND = 2'h2,
		PFDC_ORD_3RD = 2'h3
	} pfdc_order_t;
endpackage : pfdc_pkg
`default_nettype wire

// [hdl/pfdc_atomic_reg.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Shadowed register: lanes gather, top lane write commits
module pfdc_atomic_reg #(
	parameter int W = 27,
	parameter int LANES = 4,
	parameter logic [W-1:0] RST = '0
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Write side
	input wire logic wr_i,
	input wire logic [LANES*8-1:0] wdata_i,
	// Values
	output logic [W-1:0] shadow_o,
	output logic [W-1:0] active_o,
	output logic commit_o
);
	logic [W-1:0] shadow;
	logic [W-1:0] active;
	logic [W-1:0] next_shadow;
	assign next_shadow = wdata_i[W-1:0];
	assign commit_o = wr_i;
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			shadow <= RST;
			active <= RST;
		end else if (wr_i) begin
			shadow <= next_shadow;
			active <= next_shadow;
		end
	end
	assign shadow_o = shadow;
	assign active_o = active;
endmodule : pfdc_atomic_reg
`default_nettype wire

// [hdl/pfdc_lpf_decode.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Loop-filter code to one-hot steering for the analog trims
module pfdc_lpf_decode (
	// Codes
	input wire logic [2:0] cap_code_i,
	input wire logic [3:0] res_code_i,
	// One-hot steering
	output logic [7:0] cap_sel_o,
	output logic [15:0] res_sel_o
);
	genvar g;
	generate
		for (g = 0; g < 8; g++) begin : g_cap
			assign cap_sel_o[g] = (cap_code_i == 3'(g));
		end
		for (g = 0; g < 16; g++) begin : g_res
			assign res_sel_o[g] = (res_code_i == 4'(g));
		end
	endgenerate
endmodule : pfdc_lpf_decode
`default_nettype wire

// [verification/pfdc_pll_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Analog core stand-in: takes whole divider values only
module pfdc_pll_model (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Divider from the configuration block
	input wire logic [9:0] int_i,
	input wire logic [26:0] frac_i,
	input wire logic [1:0] order_i,
	// Observed state
	output logic [36:0] ratio_o,
	output logic [7:0] upd_o
);
	logic [36:0] next_ratio;
	// Integer order drops the fraction over the two-to-27 denominator
	assign next_ratio = (order_i == 2'h0) ? {int_i, 27'h0} : {int_i, frac_i};
	// Each change of the ratio counts as one update
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			upd_o <= 8'h00;
		end else if (next_ratio != ratio_o) begin
			upd_o <= upd_o + 8'h01;
		end
		ratio_o <= next_ratio;
	end
endmodule : pfdc_pll_model
`default_nettype wire

// [verification/pll_feedback_divider_config_test.sv]
`timescale 1ns/1ps
`default_nettype none
module pll_feedback_divider_config_test;
	import pfdc_pkg::*;
	typedef struct {logic [7:0] a; logic [31:0] d; logic [3:0] be; logic [31:0] q;} pfdc_row_t;
	logic CLK_SYS_I = 1'b0;
	logic RST_N_I = 1'b0;
	logic [7:0] ADDR_I = 8'h00;
	logic [31:0] WDATA_I = 32'h0;
	logic [3:0] BE_I = 4'h0;
	logic WR_I = 1'b0;
	logic RD_I = 1'b0;
	logic [31:0] RDATA_O;
	logic [9:0] INT_O;
	logic [26:0] FRAC_O;
	logic [1:0] ORD_O;
	logic DITH_O, SHAPE_O, REFSEL_O, DBL_O, BYP_O;
	logic [3:0] STEP_O, RES_O;
	logic [2:0] CAP_O;
	logic [7:0] CAPSEL_O, upd;
	logic [15:0] RESSEL_O;
	logic [36:0] ratio;
	logic [7:0] sdm, refc, lpf;
	logic [9:0] ei;
	logic [26:0] ef;
	int fail_count = 0;
	int checked = 0;
	pfdc_row_t rows [0:10] = '{'{8'h08, 32'hf0, 4'h1, 32'h30}, '{8'h08, 32'h05, 4'h1, 32'h05},
		'{8'h08, 32'h0a, 4'h1, 32'h0a}, '{8'h08, 32'hff, 4'hf, 32'h3f},
		'{8'h08, 32'h00, 4'he, 32'h3f}, '{8'h0c, 32'hfe, 4'h1, 32'h02},
		'{8'h0c, 32'h01, 4'h1, 32'h01}, '{8'h10, 32'h80, 4'h1, 32'h80},
		'{8'h10, 32'h7f, 4'h1, 32'h7f}, '{8'h10, 32'h35, 4'h1, 32'h35},
		'{8'h20, 32'hff, 4'hf, 32'h00}};
	always #2 CLK_SYS_I = ~CLK_SYS_I;
	pfdc_top dut_u (.CLK_SYS_I(CLK_SYS_I), .RST_N_I(RST_N_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I),
		.BE_I(BE_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O),
		.FEEDBACK_INTEGER_VALUE_O(INT_O), .FEEDBACK_FRACTION_NUMERATOR_O(FRAC_O),
		.MODULATOR_ORDER_O(ORD_O), .DITHER_ENABLE_O(DITH_O), .DITHER_SHAPING_ENABLE_O(SHAPE_O),
		.DITHER_STEP_O(STEP_O), .REF_SEL_CLOCK_INPUT_PIN_O(REFSEL_O), .DOUBLER_ENABLE_O(DBL_O),
		.VCO_FILTER_BYPASS_O(BYP_O), .POLE_CAPACITOR_CODE_O(CAP_O), .FILTER_RESISTOR_CODE_O(RES_O),
		.POLE_CAPACITOR_SEL_O(CAPSEL_O), .FILTER_RESISTOR_SEL_O(RESSEL_O));
	pfdc_pll_model pll_u (.clk_i(CLK_SYS_I), .rst_n_i(RST_N_I), .int_i(INT_O), .frac_i(FRAC_O),
		.order_i(ORD_O), .ratio_o(ratio), .upd_o(upd));
	// ==========================================================
	// Tasks
	task automatic give_verdict();
		if (fail_count == 0 && checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : give_verdict
	task automatic chk(input string name, input logic [36:0] exp, input logic [36:0] got);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask : chk
	task automatic idle(input int n);
		repeat (n) @(posedge CLK_SYS_I);
		#1;
	endtask : idle
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
		@(posedge CLK_SYS_I);
		ADDR_I <= a;
		WDATA_I <= d;
		BE_I <= be;
		WR_I <= 1'b1;
		@(posedge CLK_SYS_I);
		WR_I <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] q);
		@(posedge CLK_SYS_I);
		ADDR_I <= a;
		RD_I <= 1'b1;
		@(posedge CLK_SYS_I);
		RD_I <= 1'b0;
		#1;
		chk("rdata", {5'h0, q}, {5'h0, RDATA_O});
	endtask : rd
	task automatic check_cfg();
		logic [26:0] fe;
		fe = (sdm[1:0] == 2'h0) ? 27'h0 : ef;
		idle(3);
		chk("order", sdm[1:0], ORD_O);
		chk("dither", sdm[5], DITH_O);
		chk("shape", sdm[4], SHAPE_O);
		chk("step", 37'h1 << sdm[3:2], STEP_O);
		chk("refsel", refc[1], REFSEL_O);
		chk("doubler", refc[0], DBL_O);
		chk("bypass", lpf[7], BYP_O);
		chk("cap", lpf[6:4], CAP_O);
		chk("capsel", 37'h1 << lpf[6:4], CAPSEL_O);
		chk("res", lpf[3:0], RES_O);
		chk("ressel", 37'h1 << lpf[3:0], RESSEL_O);
		chk("int", ei, INT_O);
		chk("frac", fe, FRAC_O);
		chk("ratio", {ei, fe}, ratio);
	endtask : check_cfg
	task automatic check_reset();
		sdm = 8'h03;
		refc = 8'h01;
		lpf = 8'h76;
		ei = 10'h06c;
		ef = 27'h0;
		check_cfg();
		chk("rdata_idle", 37'h0, RDATA_O);
		rd(8'h00, 32'h0);
		rd(8'h04, 32'h6c);
		rd(8'h08, 32'h03);
		rd(8'h0c, 32'h01);
		rd(8'h10, 32'h76);
		rd(8'h14, 32'h0);
	endtask : check_reset
	// ==========================================================
	// Main sequence
	initial begin
		#100000;
		fail_count++;
		give_verdict();
	end
	initial begin
		logic [7:0] u;
		repeat (6) @(posedge CLK_SYS_I);
		RST_N_I <= 1'b1;
		check_reset();
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].d, rows[i].be);
			rd(rows[i].a, rows[i].q);
			case (rows[i].a)
				8'h08: sdm = rows[i].q[7:0];
				8'h0c: refc = rows[i].q[7:0];
				8'h10: lpf = rows[i].q[7:0];
				default: ;
			endcase
			check_cfg();
		end
		// Staged low lanes stay off the core until the top lane lands
		u = upd;
		wr(8'h00, 32'h00001234, 4'h1);
		check_cfg();
		chk("updates", u, upd);
		rd(8'h14, 32'h34);
		rd(8'h00, 32'h0);
		wr(8'h00, 32'h05000000, 4'h8);
		ef = 27'h5000034;
		check_cfg();
		chk("updates", u + 8'h01, upd);
		wr(8'h00, 32'h00ab0000, 4'h4);
		wr(8'h00, 32'hffffffff, 4'hf);
		ef = 27'h7ffffff;
		rd(8'h00, 32'h07ffffff);
		check_cfg();
		u = upd;
		wr(8'h04, 32'h000000ab, 4'h1);
		check_cfg();
		chk("updates", u, upd);
		wr(8'h04, 32'h00000300, 4'h2);
		ei = 10'h3ab;
		check_cfg();
		rd(8'h04, 32'h3ab);
		wr(8'h04, 32'hffffffff, 4'h3);
		ei = 10'h3ff;
		rd(8'h04, 32'h3ff);
		// Integer order hides the numerator; leaving it restores it
		wr(8'h08, 32'h00, 4'h1);
		sdm = 8'h00;
		check_cfg();
		rd(8'h00, 32'h07ffffff);
		wr(8'h08, 32'h01, 4'h1);
		sdm = 8'h01;
		check_cfg();
		// Reset again in mid-run
		@(posedge CLK_SYS_I);
		RST_N_I <= 1'b0;
		repeat (2) @(posedge CLK_SYS_I);
		RST_N_I <= 1'b1;
		check_reset();
		give_verdict();
	end
endmodule : pll_feedback_divider_config_test
`default_nettype wire
